//--- testbench/tbg_radio.sv
// loop-back radio model: frame clock source and returned bits
`timescale 1ns/10ps
module tbg_radio (
  input logic pclk,
  input logic presetn,
  input logic bb_in,
  input logic flip,
  output logic frame_clk,
  output logic demod_out
);
  logic [7:0] cnt;
  // ****
  // frame clock and loop-back
  // ****
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      frame_clk <= 1'b0;
      demod_out <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      frame_clk <= cnt[7];
      demod_out <= bb_in ^ flip;
    end
  end
endmodule

//--- testbench/tbg_top_properties.sv
// port-level checks of the pattern block
`timescale 1ns/10ps
module tbg_props #(
  parameter BIT_DIV = 8,
  parameter SLOT_BITS = 324,
  parameter MEAS_BITS = 16'd648
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic frame_clk,
  input logic ext_bb_data,
  input logic demod_data,
  input logic modulator_data,
  input logic analyzer_data,
  input logic rear_baseband_output,
  input logic bit_strobe
);
  logic ext_q;
  logic rd_setup;
  // ****
  // source tracking and checks
  // ****
  assign rd_setup = psel && !penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ext_q <= 1'b0;
    else if (psel && penable && pwrite && paddr == 12'h000)
      ext_q <= pwdata[1];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_sinks_same: assert property (modulator_data == rear_baseband_output)
    else $error("modulator and rear outputs differ");
  a_analyzer_same: assert property (analyzer_data == modulator_data)
    else $error("analyzer and modulator feeds differ");
  a_strobe_gap: assert property (bit_strobe |=> !bit_strobe [*7] ##1 bit_strobe)
    else $error("bit period not eight clocks");
  a_ext_undelayed: assert property ((ext_q && $stable(ext_bb_data)) [*6] |->
    modulator_data == ext_bb_data)
    else $error("external data not passed through");
  a_delay_cap: assert property (rd_setup && paddr == 12'h008 |=> prdata <= 32'h797)
    else $error("delay above limit");
  a_unmapped_zero: assert property (rd_setup && paddr >= 12'h020 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rd_setup |=> $stable(prdata))
    else $error("read data changed without read");
  a_ready_ok: assert property (pready && !pslverr)
    else $error("bus answer not ready and clean");
endmodule
bind tbg_top tbg_props #(.BIT_DIV(BIT_DIV), .SLOT_BITS(SLOT_BITS), .MEAS_BITS(MEAS_BITS))
  u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_clk(frame_clk), .ext_bb_data(ext_bb_data), .demod_data(demod_data),
  .modulator_data(modulator_data), .analyzer_data(analyzer_data),
  .rear_baseband_output(rear_baseband_output), .bit_strobe(bit_strobe));

//--- testbench/tbg_top_tb.sv
// self-checking bench for the pattern block
`timescale 1ns/10ps
module tbg_top_tb;
  logic pclk, presetn, psel, penable, pwrite, ext_bb_data, flip;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, frame_clk, demod_data, mod_d, anl_d, rear_d, bit_strobe;
  integer n_errors, samples_checked, i, ones;
  tbg_top #(.MEAS_BITS(16'd16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_clk(frame_clk), .ext_bb_data(ext_bb_data),
    .demod_data(demod_data), .modulator_data(mod_d), .analyzer_data(anl_d),
    .rear_baseband_output(rear_d), .bit_strobe(bit_strobe));
  tbg_radio radio (.pclk(pclk), .presetn(presetn), .bb_in(rear_d), .flip(flip),
    .frame_clk(frame_clk), .demod_out(demod_data));
  // ****
  // clock and tasks
  // ****
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    integer k;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge pclk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
        chk(0, 1);
        print_verdict;
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task cmd(input [31:0] c);
    apb(12'h004, 1'b1, c);
  endtask
  task wait_st(input integer b, input v);
    integer k;
    begin
      k = 0;
      do begin
        apb(12'h014, 1'b0, 32'h0);
        k = k + 1;
      end while (rd[b] !== v && k < 300);
      chk(rd[b], v);
      if (k >= 300)
        print_verdict;
    end
  endtask
  task frame_to(input v);
    integer k;
    begin
      k = 0;
      while (frame_clk !== v && k < 400) begin
        @(posedge pclk);
        k = k + 1;
      end
      if (k >= 400) begin
        chk(0, 1);
        print_verdict;
      end
    end
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_bb_data = 1'b0;
    flip = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 9; i = i + 1) begin
      apb(12'(i * 4), 1'b0, 32'h0);
      chk(rd, (i == 0) ? 32'h4 : 32'h0);
    end
    apb(12'h008, 1'b1, 32'hffff);
    apb(12'h008, 1'b0, 32'h0);
    chk(rd, 32'h797);
    apb(12'h008, 1'b1, 32'h28);
    frame_to(1'b1);
    frame_to(1'b0);
    cmd(32'h1);
    frame_to(1'b1);
    repeat (100) @(posedge pclk);
    apb(12'h014, 1'b0, 32'h0);
    chk(rd[0], 1'b0);
    wait_st(0, 1'b1);
    cmd(32'h2);
    apb(12'h014, 1'b0, 32'h0);
    chk(rd[0], 1'b0);
    apb(12'h008, 1'b1, 32'h0);
    cmd(32'h1);
    apb(12'h014, 1'b0, 32'h0);
    chk(rd[0], 1'b1);
    apb(12'h000, 1'b1, 32'h0);
    apb(12'h014, 1'b0, 32'h0);
    chk(rd[0], 1'b0);
    apb(12'h00c, 1'b1, 32'hffffffff);
    cmd(32'h1);
    wait_st(0, 1'b1);
    for (i = 0; i < 2; i = i + 1) begin
      flip <= i[0];
      repeat (40) @(posedge pclk);
      cmd(32'h4);
      apb(12'h014, 1'b0, 32'h0);
      chk(rd[3:1], 3'b001);
      cmd(32'h10);
      wait_st(3, 1'b1);
      apb(12'h018, 1'b0, 32'h0);
      chk(rd, 32'd16);
      apb(12'h01c, 1'b0, 32'h0);
      chk(rd, i ? 32'd16 : 32'd0);
    end
    flip <= 1'b0;
    cmd(32'h4);
    cmd(32'h10);
    apb(12'h00c, 1'b1, 32'h0);
    apb(12'h014, 1'b0, 32'h0);
    chk(rd[2:0], 3'b010);
    apb(12'h000, 1'b1, 32'h8);
    cmd(32'h4);
    cmd(32'h10);
    wait_st(4, 1'b1);
    apb(12'h008, 1'b1, 32'h797);
    apb(12'h000, 1'b1, 32'h2);
    for (i = 0; i < 4; i = i + 1) begin
      ext_bb_data <= ~ext_bb_data;
      repeat (10) @(posedge pclk);
      chk({mod_d, anl_d, rear_d}, {3{ext_bb_data}});
    end
    apb(12'h008, 1'b1, 32'h0);
    apb(12'h000, 1'b1, 32'h1);
    cmd(32'h1);
    wait_st(0, 1'b1);
    ones = 0;
    repeat (512) begin
      @(posedge pclk);
      ones = ones + rear_d;
    end
    chk(ones > 0 && ones < 512, 1'b1);
    cmd(32'h2);
    cmd(32'h4);
    i = 0;
    do begin
      @(negedge pclk);
      i = i + 1;
    end while (bit_strobe !== 1'b1 && i < 9);
    chk(bit_strobe, 1'b1);
    @(posedge pclk);
    cmd(32'h11);
    wait_st(3, 1'b1);
    apb(12'h01c, 1'b0, 32'h0);
    chk(rd, 32'd0);
    apb(12'h000, 1'b1, 32'h14);
    apb(12'h010, 1'b1, 32'hfffffff);
    apb(12'h00c, 1'b1, 32'hffffffff);
    cmd(32'h1);
    cmd(32'h4);
    cmd(32'h10);
    wait_st(3, 1'b1);
    chk(rd[5:1], 5'b10101);
    apb(12'h01c, 1'b0, 32'h0);
    chk(rd, 32'd0);
    cmd(32'h8);
    apb(12'h014, 1'b0, 32'h0);
    chk(rd[1], 1'b0);
    print_verdict;
  end
endmodule

//--- verilog/tbg_prbs.v
// pseudo-random bit source with restart and step controls
`timescale 1ns/10ps
`include "tbg_regs.vh"
module tbg_prbs #(
  parameter W = 9
) (
  input wire pclk,
  input wire presetn,
  input wire restart,
  input wire step,
  output wire bit_out
);
  reg [W-1:0] lfsr;
  // ****************************************************************
  // shift register
  // ****************************************************************
  // reproducible sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= `TBG_LFSR_SEED;
    end else if (restart) begin
      lfsr <= `TBG_LFSR_SEED;
    end else if (step) begin
      lfsr <= {lfsr[W-2:0], lfsr[W-1] ^ lfsr[4]};
    end
  end
  assign bit_out = lfsr[W-1];
endmodule

//--- verilog/tbg_regs.vh
// register offsets, field positions, reset values and timing counts of the pattern block
`ifndef TBG_REGS_VH
`define TBG_REGS_VH
// ****************************************************************
// register offsets
// ****************************************************************
`define TBG_CTRL_OFS 12'h000
`define TBG_CMD_OFS 12'h004
`define TBG_DELAY_OFS 12'h008
`define TBG_MSG_OFS 12'h00c
`define TBG_SYNC_OFS 12'h010
`define TBG_STATUS_OFS 12'h014
`define TBG_BITS_OFS 12'h018
`define TBG_ERRS_OFS 12'h01c
// ****************************************************************
// field positions
// ****************************************************************
`define TBG_CTRL_RANDOM 0
`define TBG_CTRL_EXTSRC 1
`define TBG_CTRL_CORR 2
`define TBG_CTRL_MOBILE 3
`define TBG_CTRL_CONT 4
`define TBG_CMD_SEND 0
`define TBG_CMD_STOP 1
`define TBG_CMD_ARM 2
`define TBG_CMD_DISARM 3
`define TBG_CMD_TRIG 4
`define TBG_ST_SENDING 0
`define TBG_ST_ARMED 1
`define TBG_ST_MEAS 2
`define TBG_ST_DONE 3
`define TBG_ST_ERR 4
`define TBG_ST_SYNCED 5
// ****************************************************************
// reset values and limits
// ****************************************************************
`define TBG_CTRL_RST 5'h04
`define TBG_DELAY_RST 11'h000
`define TBG_DELAY_MAX 11'h797
`define TBG_MSG_RST 32'h00000000
`define TBG_SYNC_RST 28'h0000000
`define TBG_LFSR_SEED 9'h1ff
`define TBG_SLOT_BITS 324
`define TBG_BIT_DIV 8
`endif

//--- verilog/tbg_top.v
// pattern generator, source selector and bit error analyzer with apb registers
// How it works
// - analyzer compares demodulated bits against the generator reference, counts errors
// - with correlation on, analyzer hunts the sync word and aligns to it
// - with correlation off, base station measurement starts at any bit position
// - correlation off with mobile slot type gives error status, no valid result
// - after send and frame clock rise, output waits programmed bits, 1 to 1943
// - bit delay applies to internal data only; external data passes undelayed
// - internal delayed stream feeds modulator, analyzer and rear baseband output
// - random mode emits pseudo-random data in every slot while sending
// - random mode analyzer reference is the identical generator sequence
// - repeat mode sends the message pattern again in every slot
// - source selector routes internal or external data to all three sinks
// - armed analyzer starts measuring at trigger; trigger needed after configuration
// - configuration change while armed aborts and re-arms with new settings
// - configuration change stops generator; a new send request is needed
// - send starts output at once with zero delay, else after delay
// - stop request ends generator output
`timescale 1ns/10ps
`include "tbg_regs.vh"
module tbg_top #(
  parameter BIT_DIV = `TBG_BIT_DIV,
  parameter SLOT_BITS = `TBG_SLOT_BITS,
  parameter MEAS_BITS = 16'd648
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire frame_clk,
  input wire ext_bb_data,
  input wire demod_data,
  output reg modulator_data,
  output reg analyzer_data,
  output reg rear_baseband_output,
  output wire bit_strobe
);
  localparam G_IDLE = 2'd0;
  localparam G_WAIT = 2'd1;
  localparam G_DELAY = 2'd2;
  localparam G_SEND = 2'd3;
  localparam A_IDLE = 2'd0;
  localparam A_ARMED = 2'd1;
  localparam A_HUNT = 2'd2;
  localparam A_MEAS = 2'd3;
  reg [4:0] ctrl;
  reg [10:0] delay;
  reg [31:0] msg;
  reg [27:0] sync_word;
  reg [1:0] gst;
  reg [1:0] ast;
  reg [10:0] dcnt;
  reg [8:0] slot_pos;
  reg [15:0] bit_cnt;
  reg [15:0] err_cnt;
  reg [27:0] shreg;
  reg done;
  reg meas_err;
  reg synced;
  reg [7:0] div;
  reg [2:0] fsync;
  reg [2:0] xsync;
  reg [2:0] dsync;
  reg ref_sel;
  wire wr = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire tick = (div == BIT_DIV - 1);
  wire frame_rise = fsync[1] & ~fsync[2];
  wire ext_bit = xsync[2];
  wire rx_bit = dsync[2];
  wire cfg_wr = wr & ((paddr == `TBG_CTRL_OFS) | (paddr == `TBG_DELAY_OFS) |
    (paddr == `TBG_MSG_OFS) | (paddr == `TBG_SYNC_OFS));
  wire cmd_wr = wr & (paddr == `TBG_CMD_OFS);
  wire prbs_gen;
  wire prbs_ref;
  wire int_bit;
  wire src_bit;
  wire ref_bit;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign bit_strobe = tick;
  // ****************************************************************
  // pin synchronisers and bit clock
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsync <= 3'h0;
      xsync <= 3'h0;
      dsync <= 3'h0;
      div <= 8'h00;
    end else begin
      fsync <= {fsync[1:0], frame_clk};
      xsync <= {xsync[1:0], ext_bb_data};
      dsync <= {dsync[1:0], demod_data};
      div <= tick ? 8'h00 : div + 8'h01;
    end
  end
  // ****************************************************************
  // registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `TBG_CTRL_RST;
      delay <= `TBG_DELAY_RST;
      msg <= `TBG_MSG_RST;
      sync_word <= `TBG_SYNC_RST;
    end else if (wr) begin
      if (paddr == `TBG_CTRL_OFS) begin
        ctrl <= pwdata[4:0];
      end else if (paddr == `TBG_DELAY_OFS) begin
        delay <= (pwdata > {21'h0, `TBG_DELAY_MAX}) ? `TBG_DELAY_MAX : pwdata[10:0];
      end else if (paddr == `TBG_MSG_OFS) begin
        msg <= pwdata;
      end else if (paddr == `TBG_SYNC_OFS) begin
        sync_word <= pwdata[27:0];
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      if (paddr == `TBG_CTRL_OFS) begin
        prdata <= {27'h0, ctrl};
      end else if (paddr == `TBG_DELAY_OFS) begin
        prdata <= {21'h0, delay};
      end else if (paddr == `TBG_MSG_OFS) begin
        prdata <= msg;
      end else if (paddr == `TBG_SYNC_OFS) begin
        prdata <= {4'h0, sync_word};
      end else if (paddr == `TBG_STATUS_OFS) begin
        prdata <= {26'h0, synced, meas_err, done, ast == A_MEAS || ast == A_HUNT,
          ast != A_IDLE, gst == G_SEND};
      end else if (paddr == `TBG_BITS_OFS) begin
        prdata <= {16'h0, bit_cnt};
      end else if (paddr == `TBG_ERRS_OFS) begin
        prdata <= {16'h0, err_cnt};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
  // ****************************************************************
  // generator
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gst <= G_IDLE;
      dcnt <= 11'h000;
      slot_pos <= 9'h000;
    end else if (cfg_wr) begin
      gst <= G_IDLE;
    end else if (cmd_wr && pwdata[`TBG_CMD_STOP]) begin
      gst <= G_IDLE;
    end else if (cmd_wr && pwdata[`TBG_CMD_SEND]) begin
      slot_pos <= 9'h000;
      gst <= (delay == 11'h000) ? G_SEND : G_WAIT;
    end else begin
      case (gst)
        G_WAIT: begin
          if (frame_rise) begin
            dcnt <= delay;
            slot_pos <= 9'h000;
            gst <= (delay == 11'h000) ? G_SEND : G_DELAY;
          end
        end
        G_DELAY: begin
          if (tick) begin
            if (dcnt == 11'h001) begin
              gst <= G_SEND;
            end
            dcnt <= dcnt - 11'h001;
          end
        end
        G_SEND: begin
          if (tick) begin
            slot_pos <= (slot_pos == SLOT_BITS - 1) ? 9'h000 : slot_pos + 9'h001;
          end
        end
        default: begin
          gst <= gst;
        end
      endcase
    end
  end
  tbg_prbs #(
    .W(9)
  ) u_gen_prbs (
    .pclk(pclk),
    .presetn(presetn),
    .restart(gst != G_SEND),
    .step(tick && gst == G_SEND),
    .bit_out(prbs_gen)
  );
  assign int_bit = (gst != G_SEND) ? 1'b0 :
    ctrl[`TBG_CTRL_RANDOM] ? prbs_gen : msg[slot_pos[4:0]];
  assign src_bit = ctrl[`TBG_CTRL_EXTSRC] ? ext_bit : int_bit;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulator_data <= 1'b0;
      analyzer_data <= 1'b0;
      rear_baseband_output <= 1'b0;
    end else begin
      modulator_data <= src_bit;
      analyzer_data <= src_bit;
      rear_baseband_output <= src_bit;
    end
  end
  // ****************************************************************
  // analyzer
  // ****************************************************************
  // identical reference sequence
  tbg_prbs #(
    .W(9)
  ) u_ref_prbs (
    .pclk(pclk),
    .presetn(presetn),
    .restart(ast != A_MEAS),
    .step(tick && ast == A_MEAS),
    .bit_out(prbs_ref)
  );
  assign ref_bit = ref_sel ? prbs_ref : msg[bit_cnt[4:0]];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ast <= A_IDLE;
      bit_cnt <= 16'h0000;
      err_cnt <= 16'h0000;
      shreg <= 28'h0000000;
      done <= 1'b0;
      meas_err <= 1'b0;
      synced <= 1'b0;
      ref_sel <= 1'b0;
    end else if (cfg_wr && ast != A_IDLE) begin
      ast <= A_ARMED;
      done <= 1'b0;
    end else if (cmd_wr && pwdata[`TBG_CMD_DISARM]) begin
      ast <= A_IDLE;
    end else if (cmd_wr && pwdata[`TBG_CMD_ARM]) begin
      ast <= A_ARMED;
      done <= 1'b0;
    end else begin
      if (tick) begin
        shreg <= {shreg[26:0], rx_bit};
      end
      case (ast)
        A_ARMED: begin
          if (cmd_wr && pwdata[`TBG_CMD_TRIG]) begin
            bit_cnt <= 16'h0000;
            err_cnt <= 16'h0000;
            synced <= 1'b0;
            ref_sel <= ctrl[`TBG_CTRL_RANDOM];
            meas_err <= ~ctrl[`TBG_CTRL_CORR] & ctrl[`TBG_CTRL_MOBILE];
            if (!ctrl[`TBG_CTRL_CORR] && ctrl[`TBG_CTRL_MOBILE]) begin
              done <= 1'b1;
              ast <= ctrl[`TBG_CTRL_CONT] ? A_ARMED : A_IDLE;
            end else begin
              ast <= ctrl[`TBG_CTRL_CORR] ? A_HUNT : A_MEAS;
            end
          end
        end
        A_HUNT: begin
          if (shreg == sync_word) begin
            synced <= 1'b1;
            ast <= A_MEAS;
          end
        end
        A_MEAS: begin
          if (tick) begin
            bit_cnt <= bit_cnt + 16'h0001;
            if (rx_bit != ref_bit) begin
              err_cnt <= err_cnt + 16'h0001;
            end
            if (bit_cnt == MEAS_BITS - 16'h0001) begin
              done <= 1'b1;
              ast <= ctrl[`TBG_CTRL_CONT] ? A_ARMED : A_IDLE;
            end
          end
        end
        default: begin
          ast <= ast;
        end
      endcase
    end
  end
endmodule
